// File: hdl/fpvs_host.sv
// Purpose: host sequencer that programs and verifies one flash page
// Assumes: device bus synchronous to i_mclk, read data one cycle after rd
// Notes:   big-endian verify word, byte at lowest address in bits 31:24
`timescale 1ns/10ps
`default_nettype none
`include "fpvs_defines.svh"

module fpvs_host
   import fpvs_pkg::*;
#(
   parameter logic [15:0] PSU_CYC    = 16'(`FPVS_CYC(`FPVS_T_PSU_US)),
   parameter logic [15:0] PULSE_CYC  = 16'(`FPVS_CYC(`FPVS_T_PULSE_US)),
   parameter logic [15:0] SWEOFF_CYC = 16'(`FPVS_CYC(`FPVS_T_SWEOFF_US)),
   parameter logic [15:0] WDOG_CYC   = 16'(`FPVS_CYC(`FPVS_T_WDOG_US))
)
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // software register port
   input  wire logic [8:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output var  logic [31:0] o_rdata,
   // device bus
   output var  logic [23:0] o_dev_addr,
   output var  logic [7:0]  o_dev_wdata,
   output var  logic        o_dev_wr,
   output var  logic        o_dev_rd,
   input  wire logic [31:0] i_dev_rdata,
   // device pin
   output var  logic        o_write_protect_pin
);
   localparam logic [15:0] SWE_CYC  = 16'(`FPVS_CYC(`FPVS_T_SWE_US));
   localparam logic [15:0] POFF_CYC = 16'(`FPVS_CYC(`FPVS_T_POFF_US));
   localparam logic [15:0] SOFF_CYC = 16'(`FPVS_CYC(`FPVS_T_PSUOFF_US));
   localparam logic [15:0] PV_CYC   = 16'(`FPVS_CYC(`FPVS_T_PV_US));
   localparam logic [15:0] DUM_CYC  = 16'(`FPVS_CYC(`FPVS_T_DUMMY_US));
   localparam logic [15:0] PVO_CYC  = 16'(`FPVS_CYC(`FPVS_T_PVOFF_US));

   fpvs_state_t state, ret, next_state, next_ret, rs;
   logic [7:0]  pbuf [0:127];
   logic [127:0] valid;
   logic [23:0] page_addr;
   logic [6:0]  idx, next_idx;
   logic [4:0]  word, next_word;
   logic [9:0]  loops, next_loops;
   logic        need, next_need, rd_q;
   logic        done, fail, align_err, wdog_err;
   logic        wdog_run;
   logic [15:0] wdog_cnt;
   logic [23:0] next_addr;
   logic [7:0]  next_wdata, cv;
   logic        next_wr, next_rd, cw;
   logic [15:0] cyc;
   logic [31:0] rp_word, next_rdata;

   fpvs_tmr_if tif ();

   fpvs_timer u_timer
   (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .t       (tif.tmr)
   );

   // byte as the device must see it: never-written bytes go out erased
   function automatic logic [7:0] fill_byte(input logic v, input logic [7:0] b);
      fill_byte = v ? b : `FPVS_ERASED;
   endfunction

   // keeps a 0 only where a 0 was wanted and the cell still reads 1
   function automatic logic [7:0] reprog(input logic [7:0] cur, input logic [7:0] rd);
      reprog = cur | ~rd;
   endfunction

   // software decode
   wire busy      = (state != S_IDLE);
   wire sel_cmd   = (i_addr == `FPVS_REG_CMD);
   wire sel_page  = (i_addr == `FPVS_REG_PAGE);
   wire sel_stat  = (i_addr == `FPVS_REG_STAT);
   wire sel_buf   = (i_addr[8:7] == `FPVS_BUF_SEL);
   wire page_ok   = (page_addr[7:0] == `FPVS_HALF_A) ||
                    (page_addr[7:0] == `FPVS_HALF_B);
   wire start_req = i_wr & sel_cmd & i_wdata[`FPVS_CMD_START] & ~busy;
   wire go        = start_req & page_ok;
   wire bad_start = start_req & ~page_ok;
   wire clr_req   = i_wr & sel_cmd & i_wdata[`FPVS_CMD_CLEAR] & ~busy;
   wire sw_buf_wr = i_wr & sel_buf & ~busy;
   wire wdog_hit  = wdog_run & (wdog_cnt >= WDOG_CYC);
   wire vcap      = (state == S_VCMP) & rd_q;
   wire [23:0] word_addr = {page_addr[23:7], word, 2'b00};
   wire [31:0] stat_word = {6'h00, loops, 11'h000, wdog_err, align_err,
                            fail, done, busy};

   // reprogram data for the word being verified
   always_comb
   begin
      rp_word = 32'h0000_0000;
      for (int j = 0; j < 4; j++)
      begin
         rp_word[31-8*j -: 8] = reprog(fill_byte(valid[{word, 2'(j)}],
                                                 pbuf[{word, 2'(j)}]),
                                       i_dev_rdata[31-8*j -: 8]);
      end
   end

   // register read selection, answered one cycle later
   always_comb
   begin
      if (i_rd && sel_stat)
         next_rdata = stat_word;
      else if (i_rd && sel_page)
         next_rdata = {8'h00, page_addr};
      else if (i_rd && sel_buf)
         next_rdata = {24'h00_0000, fill_byte(valid[i_addr[6:0]], pbuf[i_addr[6:0]])};
      else
         next_rdata = 32'h0000_0000;
   end

   // sequencer: each control write loads the timer and parks in S_WAIT
   always_comb
   begin
      next_state = state;
      next_ret   = ret;
      next_idx   = idx;
      next_word  = word;
      next_loops = loops;
      next_need  = need;
      next_addr  = o_dev_addr;
      next_wdata = o_dev_wdata;
      next_wr    = 1'b0;
      next_rd    = 1'b0;
      cw         = 1'b0;
      cv         = `FPVS_CV_OFF;
      cyc        = 16'h0000;
      rs         = S_IDLE;
      tif.load   = 1'b0;
      tif.count  = 16'h0000;
      case (state)
         S_IDLE:
            if (go)
            begin
               next_state = S_SWE_ON;
               next_loops = 10'h000;
            end
         S_SWE_ON:
         begin
            cw = 1'b1; cv = `FPVS_CV_SWE; cyc = SWE_CYC; rs = S_LOAD;
            next_idx = 7'h00;
         end
         S_LOAD:
         begin
            // whole page every pass, unwritten bytes as FF
            next_wr    = 1'b1;
            next_addr  = {page_addr[23:7], idx};
            next_wdata = fill_byte(valid[idx], pbuf[idx]);
            next_idx   = idx + 7'h01;
            if (idx == `FPVS_LAST_BYTE)
               next_state = S_PSU_ON;
         end
         S_PSU_ON:
         begin
            cw = 1'b1; cv = `FPVS_CV_PSU; cyc = PSU_CYC; rs = S_P_ON;
         end
         S_P_ON:
         begin
            cw = 1'b1; cv = `FPVS_CV_P; cyc = PULSE_CYC; rs = S_P_OFF;
            next_loops = loops + 10'h001;
         end
         S_P_OFF:
         begin
            cw = 1'b1; cv = `FPVS_CV_PSU; cyc = POFF_CYC; rs = S_PSU_OFF;
         end
         S_PSU_OFF:
         begin
            cw = 1'b1; cv = `FPVS_CV_SWE; cyc = SOFF_CYC; rs = S_PV_ON;
         end
         S_PV_ON:
         begin
            cw = 1'b1; cv = `FPVS_CV_PV; cyc = PV_CYC; rs = S_DUMMY;
            next_word = 5'h00;
            next_need = 1'b0;
         end
         S_DUMMY:
         begin
            next_wr    = 1'b1;
            next_addr  = word_addr;
            next_wdata = `FPVS_ERASED;
            tif.load   = 1'b1;
            tif.count  = DUM_CYC;
            next_ret   = S_VREAD;
            next_state = S_WAIT;
         end
         S_VREAD:
         begin
            next_rd    = 1'b1;
            next_addr  = word_addr;
            next_state = S_VCMP;
         end
         S_VCMP:
            if (rd_q)
            begin
               next_need = need | (rp_word != 32'hFFFF_FFFF);
               next_word = word + 5'h01;
               next_state = (word == `FPVS_LAST_WORD) ? S_PV_OFF : S_DUMMY;
            end
         S_PV_OFF:
         begin
            cw = 1'b1; cv = `FPVS_CV_SWE; cyc = PVO_CYC; rs = S_CHECK;
         end
         S_CHECK:
         begin
            next_idx = 7'h00;
            if (need && (loops < `FPVS_MAX_LOOPS) && !wdog_err)
               next_state = S_LOAD;
            else
               next_state = S_SWE_OFF;
         end
         S_SWE_OFF:
         begin
            cw = 1'b1; cv = `FPVS_CV_OFF; cyc = SWEOFF_CYC; rs = S_IDLE;
         end
         S_WAIT:
            if (wdog_hit && (ret == S_P_OFF))
               next_state = S_P_OFF;
            else if (tif.done)
               next_state = ret;
         default:
            next_state = S_IDLE;
      endcase
      // common control-register write, issued only from this logic
      if (cw)
      begin
         next_wr    = 1'b1;
         next_addr  = `FPVS_CTRL_ADDR;
         next_wdata = cv;
         tif.load   = 1'b1;
         tif.count  = cyc;
         next_ret   = rs;
         next_state = S_WAIT;
      end
   end

   // sequencer registers and bus outputs
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state <= S_IDLE;
         ret <= S_IDLE;
         idx <= 7'h00;
         word <= 5'h00;
         loops <= 10'h000;
         need <= 1'b0;
         rd_q <= 1'b0;
         o_dev_addr <= 24'h00_0000;
         o_dev_wdata <= 8'h00;
         o_dev_wr <= 1'b0;
         o_dev_rd <= 1'b0;
         o_write_protect_pin <= 1'b1;
         o_rdata <= 32'h0000_0000;
      end
      else
      begin
         state <= next_state;
         ret <= next_ret;
         idx <= next_idx;
         word <= next_word;
         loops <= next_loops;
         need <= next_need;
         rd_q <= o_dev_rd;
         o_dev_addr <= next_addr;
         o_dev_wdata <= next_wdata;
         o_dev_wr <= next_wr;
         o_dev_rd <= next_rd;
         o_write_protect_pin <= (next_state == S_IDLE); // low only while busy
         o_rdata <= next_rdata;
      end
   end

   // software page, status and watchdog
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         valid <= '0;
         page_addr <= 24'h00_0000;
         {done, fail, align_err, wdog_err} <= 4'h0;
         wdog_run <= 1'b0;
         wdog_cnt <= 16'h0000;
      end
      else
      begin
         if (i_wr && sel_page && !busy)
            page_addr <= i_wdata[23:0];
         if (clr_req)
            valid <= '0;
         else if (sw_buf_wr)
            valid[i_addr[6:0]] <= 1'b1;
         else if (vcap)
            valid[{word, 2'b00} +: 4] <= 4'hF;
         if (go)
            {done, fail, align_err, wdog_err} <= 4'h0;
         else if (bad_start)
            align_err <= 1'b1;
         else if (state == S_SWE_OFF)
         begin
            done <= 1'b1;
            fail <= need | wdog_err;
         end
         if (wdog_hit)
            wdog_err <= 1'b1;
         // armed before setup, stopped before verify
         wdog_run <= (state == S_PSU_ON) | (wdog_run & (state != S_PV_ON));
         wdog_cnt <= wdog_run ? wdog_cnt + 16'h0001 : 16'h0000;
      end
   end

   // page array, no reset: contents are qualified by valid
   always_ff @(posedge i_mclk)
   begin
      if (sw_buf_wr)
         pbuf[i_addr[6:0]] <= i_wdata[7:0];
      else if (vcap)
         for (int j = 0; j < 4; j++)
            pbuf[{word, 2'(j)}] <= rp_word[31-8*j -: 8];
   end

   // assertion helpers: cycles since last control write / any write
   logic [15:0] since_ctrl, since_wr;
   wire ctrl_out = o_dev_wr && (o_dev_addr == `FPVS_CTRL_ADDR);
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         since_ctrl <= 16'hFFFF;
         since_wr <= 16'hFFFF;
      end
      else
      begin
         since_ctrl <= ctrl_out ? 16'h0000 : since_ctrl + {15'h0000, since_ctrl != 16'hFFFF};
         since_wr <= o_dev_wr ? 16'h0000 : since_wr + {15'h0000, since_wr != 16'hFFFF};
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   swe_load_gap_a: assert property (o_dev_wr && !ctrl_out |-> since_ctrl >= SWE_CYC)
      else $error("page write too soon after control write");
   page_align_a: assert property (state == S_LOAD && idx == 7'h00 |-> page_ok)
      else $error("page start address not aligned");
   ff_fill_a: assert property (state == S_LOAD && !valid[idx] |=> o_dev_wdata == `FPVS_ERASED)
      else $error("unused page byte not FF");
   psu_to_p_a: assert property (ctrl_out && o_dev_wdata == `FPVS_CV_P
                                |-> since_ctrl >= PSU_CYC && $past(o_dev_wdata, 1) != 8'hFF)
      else $error("program bit set too early");
   poff_gap_a: assert property (ctrl_out && o_dev_wdata == `FPVS_CV_SWE && ret == S_PV_ON
                                |-> since_ctrl >= POFF_CYC)
      else $error("setup bit cleared too soon after program bit");
   pv_entry_a: assert property (ctrl_out && o_dev_wdata == `FPVS_CV_PV
                                |-> since_ctrl >= SOFF_CYC && !wdog_run)
      else $error("verify entered too early or watchdog running");
   dummy_gap_a: assert property (o_dev_wr && o_dev_wdata == `FPVS_ERASED && state == S_WAIT
                                 && ret == S_VREAD |-> since_ctrl >= PV_CYC)
      else $error("dummy write too early");
   read_gap_a: assert property (o_dev_rd |-> since_wr >= DUM_CYC ##2 state != S_VCMP)
      else $error("verify read too early");
   swe_clear_a: assert property (ctrl_out && o_dev_wdata == `FPVS_CV_OFF
                                 |-> since_ctrl >= PVO_CYC)
      else $error("write enable cleared too early");
   loop_cap_a: assert property (loops <= `FPVS_MAX_LOOPS)
      else $error("too many program passes");
   wp_low_a: assert property (o_dev_wr && busy |-> !o_write_protect_pin)
      else $error("write protect high during operation");

   pass_c: cover property (state == S_SWE_OFF && !need);
   retry_c: cover property (state == S_CHECK && need ##1 state == S_LOAD);
   verify_c: cover property (o_dev_rd ##2 state != S_VCMP);
   refuse_c: cover property (bad_start);
endmodule
`default_nettype wire

// File: hdl/fpvs_defines.svh
// Purpose: named numbers of the flash program/verify host sequencer
// Assumes: 200 MHz i_mclk; device control byte at a fixed address, page start on a 128-byte boundary
// Notes:   times in microseconds, cycle counts derived from them
`ifndef FPVS_DEFINES_SVH
`define FPVS_DEFINES_SVH

// clock and timing, times in microseconds
`define FPVS_CLK_MHZ      200
`define FPVS_T_SWE_US     1
`define FPVS_T_PSU_US     50
`define FPVS_T_PULSE_US   30
`define FPVS_T_POFF_US    5
`define FPVS_T_PSUOFF_US  5
`define FPVS_T_PV_US      4
`define FPVS_T_DUMMY_US   2
`define FPVS_T_PVOFF_US   2
`define FPVS_T_SWEOFF_US  100
`define FPVS_T_WDOG_US    200
`define FPVS_CYC(us)      ((us) * `FPVS_CLK_MHZ)
`define FPVS_MAX_LOOPS    10'h3E8

// device side
`define FPVS_CTRL_ADDR    24'hFFFF80
`define FPVS_ERASED       8'hFF
`define FPVS_HALF_A       8'h00
`define FPVS_HALF_B       8'h80
`define FPVS_LAST_BYTE    7'h7F
`define FPVS_LAST_WORD    5'h1F
`define FPVS_CV_OFF       8'h00
`define FPVS_CV_SWE       8'h40
`define FPVS_CV_PSU       8'h50
`define FPVS_CV_P         8'h51
`define FPVS_CV_PV        8'h44

// software register map
`define FPVS_REG_CMD      9'h000
`define FPVS_REG_PAGE     9'h004
`define FPVS_REG_STAT     9'h008
`define FPVS_BUF_SEL      2'h2
`define FPVS_CMD_START    0
`define FPVS_CMD_CLEAR    2
`define FPVS_ST_BUSY      0
`define FPVS_ST_DONE      1
`define FPVS_ST_FAIL      2
`define FPVS_ST_ALIGN     3
`define FPVS_ST_WDOG      4
`define FPVS_ST_LOOP      16

`endif

// File: hdl/fpvs_pkg.sv
// Purpose: types of the flash program/verify host sequencer
// Assumes: nothing beyond the defines header
// Notes:   one-hot state codes
package fpvs_pkg;
   typedef enum logic [14:0] {
      S_IDLE    = 15'h0001,
      S_SWE_ON  = 15'h0002,
      S_LOAD    = 15'h0004,
      S_PSU_ON  = 15'h0008,
      S_P_ON    = 15'h0010,
      S_P_OFF   = 15'h0020,
      S_PSU_OFF = 15'h0040,
      S_PV_ON   = 15'h0080,
      S_DUMMY   = 15'h0100,
      S_VREAD   = 15'h0200,
      S_VCMP    = 15'h0400,
      S_PV_OFF  = 15'h0800,
      S_CHECK   = 15'h1000,
      S_SWE_OFF = 15'h2000,
      S_WAIT    = 15'h4000
   } fpvs_state_t;
endpackage

// File: hdl/fpvs_tmr_if.sv
// Purpose: link between the sequencer and its wait timer
// Assumes: single clock domain
// Notes:   load is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface fpvs_tmr_if;
   logic        load;
   logic [15:0] count;
   logic        done;
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// File: hdl/fpvs_timer.sv
// Purpose: down-counter that times the waits of the sequencer
// Assumes: count loaded is the least number of cycles to wait
// Notes:   done is high while the count stands at zero
`timescale 1ns/10ps
`default_nettype none
module fpvs_timer
   import fpvs_pkg::*;
(
   // clock and reset
   input  wire logic i_mclk,
   input  wire logic i_reset,
   // timer link
   fpvs_tmr_if.tmr   t
);
   logic [15:0] cnt;

   // reload wins over the running count
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
         cnt <= 16'h0000;
      else if (t.load)
         cnt <= t.count;
      else if (cnt != 16'h0000)
         cnt <= cnt - 16'h0001;
   end

   assign t.done = (cnt == 16'h0000);
endmodule
`default_nettype wire

// File: sim/fpvs_flash_model.sv
// Purpose: behavioural flash array with control byte, page latch and verify
// Assumes: control byte and bus timing as the sequencer drives them
// Notes:   bits program only after i_need pulses, forcing repeat passes
`timescale 1ns/10ps
`default_nettype none
`include "fpvs_defines.svh"
module fpvs_flash_model
   import fpvs_pkg::*;
#(
   parameter logic [15:0] PSU_MIN = 16'h0032
)
(
   // clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // device bus
   input  wire logic [23:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output var  logic [31:0] o_rdata,
   // pin and slowness
   input  wire logic        i_write_protect_pin,
   input  wire logic [3:0]  i_need
);
   logic [7:0]  mem [int];
   logic [7:0]  latch [128];
   logic [7:0]  ctrl;
   logic [7:0]  prev;
   logic [23:0] base;
   logic [23:0] vaddr;
   logic        p_ok;
   int          cyc;
   int          t_ctl;
   int          t_swe;
   int          t_dum;
   int          nbytes;
   int          pulses;
   int          n_wr = 0;
   int          viol = 0;

   function automatic logic [7:0] peek(input int a);
      return mem.exists(a) ? mem[a] : `FPVS_ERASED;
   endfunction

   task automatic check(input logic c);
      if (!c)
         viol++;
   endtask

   // pulse end writes latched zeros into the array
   task automatic program_page();
      for (int i = 0; i < 128; i++)
      begin
         check((~latch[i] & ~peek(base + i)) == 8'h00);
         if (pulses >= int'(i_need))
            mem[base + i] = peek(base + i) & latch[i];
      end
   endtask

   // legal mode changes and the least gaps between them
   task automatic control_change();
      case ({prev, ctrl})
         {`FPVS_CV_OFF, `FPVS_CV_SWE}: t_swe = cyc;
         {`FPVS_CV_SWE, `FPVS_CV_PSU}:
         begin
            check(nbytes == 128);
            nbytes = 0;
         end
         {`FPVS_CV_PSU, `FPVS_CV_P}:
         begin
            check(cyc - t_ctl >= int'(PSU_MIN));
            p_ok = 1'h1;
            pulses++;
            check(pulses <= 1000);
         end
         {`FPVS_CV_P, `FPVS_CV_PSU}:
         begin
            if (p_ok)
               program_page();
            p_ok = 1'h0;
         end
         {`FPVS_CV_PSU, `FPVS_CV_SWE}: check(cyc - t_ctl >= `FPVS_CYC(`FPVS_T_POFF_US));
         {`FPVS_CV_SWE, `FPVS_CV_PV}: check(cyc - t_ctl >= `FPVS_CYC(`FPVS_T_PSUOFF_US));
         {`FPVS_CV_PV, `FPVS_CV_SWE}: t_dum = cyc;
         {`FPVS_CV_SWE, `FPVS_CV_OFF}:
         begin
            check(cyc - t_ctl >= `FPVS_CYC(`FPVS_T_PVOFF_US));
            pulses = 0;
         end
         default: viol++;
      endcase
   endtask

   // one device write: control byte, page byte or dummy write
   task automatic write_cycle();
      n_wr++;
      if (i_addr == `FPVS_CTRL_ADDR)
      begin
         if (!i_write_protect_pin)
         begin
            prev = ctrl;
            ctrl = i_wdata;
            control_change();
            t_ctl = cyc;
         end
      end
      else if (ctrl == `FPVS_CV_SWE)
      begin
         if (nbytes == 0)
         begin
            base = i_addr;
            check(i_addr[7:0] == `FPVS_HALF_A || i_addr[7:0] == `FPVS_HALF_B);
            check(cyc - t_swe >= `FPVS_CYC(`FPVS_T_SWE_US));
         end
         check(i_addr[23:7] == base[23:7]);
         latch[i_addr[6:0]] = i_wdata;
         nbytes++;
      end
      else if (ctrl == `FPVS_CV_PV)
      begin
         check(i_wdata == `FPVS_ERASED);
         check(cyc - t_ctl >= `FPVS_CYC(`FPVS_T_PV_US));
         vaddr = i_addr;
         t_dum = cyc;
      end
      else
         viol++;
   endtask

   // bus answers; outside a verify read the data lines keep changing
   always @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         // reset leaves the array contents as they were
         ctrl = `FPVS_CV_OFF;
         nbytes = 0;
         pulses = 0;
         p_ok = 1'h0;
         cyc = 0;
         o_rdata <= 32'h0;
      end
      else
      begin
         cyc++;
         o_rdata <= ~o_rdata;
         if (i_wr)
            write_cycle();
         if (i_rd)
         begin
            check(ctrl == `FPVS_CV_PV && i_addr == vaddr);
            check(cyc - t_dum >= `FPVS_CYC(`FPVS_T_DUMMY_US));
            if (ctrl == `FPVS_CV_PV)
               o_rdata <= {peek(vaddr), peek(vaddr + 1), peek(vaddr + 2), peek(vaddr + 3)};
         end
      end
   end
endmodule
`default_nettype wire

// File: sim/fpvs_host_test.sv
// Purpose: self-checking bench of the flash program/verify sequencer
// Assumes: shortened wait parameters, slow model forces a second pass
// Notes:   expected array contents kept in the bench from the page data
`timescale 1ns/10ps
`default_nettype none
module fpvs_host_test
   import fpvs_pkg::*;
;
   localparam logic [15:0] PSU_CYC = 16'h0032;
   logic        i_mclk;
   logic        i_reset;
   logic [8:0]  i_addr;
   logic [31:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rdata;
   logic [23:0] dev_addr;
   logic [7:0]  dev_wdata;
   logic        dev_wr;
   logic        dev_rd;
   logic [31:0] dev_rdata;
   logic        wp_pin;
   logic [3:0]  need;
   logic [31:0] d;
   logic [7:0]  page [128];
   logic [7:0]  exp_mem [int];
   int          fail_count = 0;
   int          checks = 0;
   int          n;

   // watchdog span must cover setup, pulse and both 5 us clear gaps (~2100 cycles)
   fpvs_host #(.PSU_CYC(PSU_CYC), .PULSE_CYC(16'h001E), .SWEOFF_CYC(16'h0064),
      .WDOG_CYC(16'h0BB8)) fpvs_host_i (.i_mclk(i_mclk), .i_reset(i_reset),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_dev_addr(dev_addr), .o_dev_wdata(dev_wdata), .o_dev_wr(dev_wr),
      .o_dev_rd(dev_rd), .i_dev_rdata(dev_rdata), .o_write_protect_pin(wp_pin));
   fpvs_flash_model #(.PSU_MIN(PSU_CYC)) fpvs_flash_model_i (.i_mclk(i_mclk),
      .i_reset(i_reset), .i_addr(dev_addr), .i_wdata(dev_wdata), .i_wr(dev_wr),
      .i_rd(dev_rd), .o_rdata(dev_rdata), .i_write_protect_pin(wp_pin), .i_need(need));

   // 200 MHz clock
   always #2.5 i_mclk = ~i_mclk;

   task automatic complete_run();
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic compare(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [31:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'h1;
      @(posedge i_mclk);
      i_wr <= 1'h0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [8:0] a, output logic [31:0] v);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      #1 v = o_rdata;
   endtask

   // load a sparse random page, run it, compare array with bench copy
   task automatic run_page(input logic [23:0] pg, input logic [3:0] nd);
      need <= nd;
      wr(9'h000, 32'h4);
      for (int i = 0; i < 128; i++)
      begin
         page[i] = 8'hFF;
         if ($urandom % 4 != 0)
         begin
            page[i] = 8'($urandom);
            wr(9'h100 + 9'(i), {24'h0, page[i]});
         end
      end
      for (int i = 0; i < 128; i++)
      begin
         rd(9'h100 + 9'(i), d);
         compare(d, {24'h0, page[i]});
      end
      wr(9'h004, {8'h0, pg});
      wr(9'h000, 32'h1);
      rd(9'h008, d);
      compare({31'h0, d[0]}, 32'h1);
      compare({31'h0, wp_pin}, 32'h0);
      wr(9'h004, 32'h0);
      rd(9'h004, d);
      compare(d, {8'h0, pg});
      n = 0;
      do
      begin
         rd(9'h008, d);
         n++;
      end
      while (d[0] === 1'h1 && n < 30000);
      compare(d, {6'h0, 6'h0, nd, 16'h0002});
      compare({31'h0, wp_pin}, 32'h1);
      for (int i = 0; i < 128; i++)
      begin
         exp_mem[pg + i] = (exp_mem.exists(pg + i) ? exp_mem[pg + i] : 8'hFF) & page[i];
         compare({24'h0, fpvs_flash_model_i.peek(pg + i)}, {24'h0, exp_mem[pg + i]});
      end
   endtask

   // watchdog: the whole run needs some 51000 cycles
   initial
   begin
      repeat (90000) @(posedge i_mclk);
      fail_count++;
      complete_run();
   end

   // main sequence
   initial
   begin
      i_mclk = 1'h0;
      i_reset = 1'h1;
      i_addr = 9'h0;
      i_wdata = 32'h0;
      i_wr = 1'h0;
      i_rd = 1'h0;
      need = 4'h1;
      void'($urandom(80468));
      repeat (10) @(posedge i_mclk);
      i_reset <= 1'h0;
      compare(o_rdata, 32'h0);
      compare({31'h0, wp_pin}, 32'h1);
      rd(9'h008, d);
      compare(d, 32'h0);
      rd(9'h0C0, d);
      compare(d, 32'h0);
      // misaligned page start must not reach the device
      wr(9'h004, 32'h001040);
      n = fpvs_flash_model_i.n_wr;
      wr(9'h000, 32'h1);
      repeat (4) @(posedge i_mclk);
      rd(9'h008, d);
      compare({27'h0, d[4:0]}, 32'h8);
      compare(32'(fpvs_flash_model_i.n_wr), 32'(n));
      run_page(24'h012300, 4'h2);
      run_page(24'h012380, 4'h1);
      compare(32'(fpvs_flash_model_i.viol), 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
